/* File: aperture_ref_defs.vh */
// constants for the aperture delay and reference windowing block
// assumes an apb slave at 32-bit data, word-aligned registers
//
// What this block does
// - invert control adds exactly half a clock period of delay.
// - coarse and fine delays each offer 256 settings as separate codes.
// - invert, coarse and fine act independently and their delays add.
// - all internal clocks shift by total delay, moving output and capture.
// - delay may change live; link may glitch; host should use ramp.
// - with ramp on, applied coarse delay steps toward new written value.
// - ramp speed selects 1 or 4 coarse steps per 384 clocks.
// - with ramp on, each coarse write starts a new ramp.
// - reference captured on a deterministic clock edge every power-on.
// - single-channel mode samples both edges, doubling reference window.
// - detector stores reference position in a readable flag vector.
// - position flags valid only after 3 reference rising edges.
// - flag bit 1 marks possible setup/hold violation, 0 a valid position.
// - 24 positions exist; select field takes only 0 to 15.
// - position bits 0 and 23 always read as 1.
// - zoom 0 gives coarse position steps, 1 gives fine steps.
// - calibration searches delays until clock falls at reference rise.
`ifndef APERTURE_REF_DEFS_VH
`define APERTURE_REF_DEFS_VH

`define ADDR_DELAY_CTRL 12'h000
`define ADDR_REF_CTRL   12'h004
`define ADDR_REF_POS    12'h008
`define ADDR_STATUS     12'h00c

// delay control fields
`define DLY_COARSE_LSB  0
`define DLY_FINE_LSB    8
`define DLY_INV_BIT     16
`define DLY_RAMP_EN_BIT 17
`define DLY_RAMP_FAST   18
`define DLY_CTRL_RESET  32'h0000_0000

// reference control fields
`define REF_SEL_LSB     0
`define REF_FINE_BIT    4
`define REF_SINGLE_BIT  5
`define REF_CAL_BIT     6
`define REF_CTRL_RESET  32'h0000_0000

// status fields
`define STS_COARSE_LSB  0
`define STS_FINE_LSB    8
`define STS_INV_BIT     16
`define STS_RAMPING_BIT 17
`define STS_CAL_BUSY    18
`define STS_CAL_DONE    19
`define POS_VALID_BIT   24

`define DELAY_SETTINGS  256
`define POS_COUNT       24
`define SEL_COUNT       16
`define REF_EDGES_VALID 3
`define RAMP_PERIOD     384
`define RAMP_SLOW_STEP  1
`define RAMP_FAST_STEP  4
`define CAL_SETTLE      64

`endif

/* File: aperture_ref_window.v */
// aperture delay control, coarse ramp, reference position detector,
// reference sample selection and delay search, with an apb register file
// assumes all inputs synchronous to pclk; analog delay line outside
`timescale 1ns/1ps
`include "aperture_ref_defs.vh"

module aperture_ref_window #(
  parameter POS_W      = `POS_COUNT,
  parameter RAMP_LEN   = `RAMP_PERIOD,
  parameter SETTLE_LEN = `CAL_SETTLE,
  parameter HALF_UNITS = 16'd2000,
  parameter CRS_UNITS  = 16'd20,
  parameter FINE_UNITS = 16'd1
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             clk_en,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  input  wire [POS_W-1:0] ref_tap_samples,
  input  wire             ref_edge_aligned,
  output reg              clock_invert_select,
  output reg  [7:0]       coarse_delay_code,
  output reg  [7:0]       fine_delay_code,
  output reg  [23:0]      total_delay_units,
  output reg              ref_step_fine,
  output reg              sample_both_edges,
  output reg              ref_captured,
  output reg              ref_capture_pulse
);

  localparam CAL_IDLE   = 2'd0;
  localparam CAL_SETTLE = 2'd1;
  localparam CAL_CHECK  = 2'd2;
  localparam CAL_DONE   = 2'd3;

  reg [31:0]      dly_ctrl_ff;
  reg [31:0]      ref_ctrl_ff;
  reg [7:0]       coarse_act_ff;
  reg [7:0]       fine_act_ff;
  reg             inv_act_ff;
  reg [8:0]       ramp_cnt_ff;
  reg [POS_W-1:0] flags_ff;
  reg [1:0]       edge_cnt_ff;
  reg             center_ff;
  reg             cap_ff;
  reg [1:0]       cal_state_ff;
  reg [7:0]       cal_wait_ff;
  reg             cal_en_d_ff;

  wire       wr_en   = clk_en & psel & penable & pwrite;
  wire       wr_dly  = wr_en & (paddr == `ADDR_DELAY_CTRL);
  wire       wr_ref  = wr_en & (paddr == `ADDR_REF_CTRL);
  wire [7:0] coarse_target = dly_ctrl_ff[`DLY_COARSE_LSB +: 8];
  wire       ramp_en   = dly_ctrl_ff[`DLY_RAMP_EN_BIT];
  wire       ramp_fast = dly_ctrl_ff[`DLY_RAMP_FAST];
  wire [3:0] sel       = ref_ctrl_ff[`REF_SEL_LSB +: 4];
  wire       cal_en    = ref_ctrl_ff[`REF_CAL_BIT];
  wire       cal_busy  = (cal_state_ff == CAL_SETTLE) |
                         (cal_state_ff == CAL_CHECK);
  // the search owns the coarse code, so it is not a ramp meanwhile
  wire       ramping   = (coarse_act_ff != coarse_target) & ~cal_busy;
  wire       cal_done  = (cal_state_ff == CAL_DONE);
  // one ramp step per period of enabled cycles
  wire       ramp_tick = (ramp_cnt_ff == RAMP_LEN - 1);
  wire       pos_valid = (edge_cnt_ff == 2'd`REF_EDGES_VALID);
  wire       center_now = ref_tap_samples[POS_W/2];
  wire       ref_rise   = center_now & ~center_ff;

  // a single step of the ramp, never overshooting the target
  function [7:0] ramp_step;
    input [7:0] cur;
    input [7:0] tgt;
    input       fast;
    reg   [8:0] step;
    begin
      step = fast ? 9'd`RAMP_FAST_STEP : 9'd`RAMP_SLOW_STEP;
      if (tgt > cur)
        ramp_step = ({1'b0, tgt} - {1'b0, cur} <= step) ? tgt :
                    cur + step[7:0];
      else
        ramp_step = ({1'b0, cur} - {1'b0, tgt} <= step) ? tgt :
                    cur - step[7:0];
    end
  endfunction

  // one decode of the four word registers; anything else is refused
  function addr_mapped;
    input [11:0] a;
    begin
      addr_mapped = (a == `ADDR_DELAY_CTRL) | (a == `ADDR_REF_CTRL) |
                    (a == `ADDR_REF_POS) | (a == `ADDR_STATUS);
    end
  endfunction

  // a tap that disagrees with either neighbour sits close to a clock edge
  function edge_near;
    input left;
    input mid;
    input right;
    begin
      edge_near = (mid ^ left) | (mid ^ right);
    end
  endfunction

  // weighted sum of the three delay parts, kept at the output width
  function [23:0] delay_units;
    input       inv;
    input [7:0] crs;
    input [7:0] fin;
    begin
      delay_units = (inv ? {8'h00, HALF_UNITS} : 24'h000000) +
                    crs * CRS_UNITS +
                    fin * FINE_UNITS;
    end
  endfunction

  // zero wait states: every access phase completes at its first edge
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped(paddr);

  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_ctrl_ff <= `DLY_CTRL_RESET;
      ref_ctrl_ff <= `REF_CTRL_RESET;
    end else if (clk_en) begin
      // live rewrites are allowed; the ramp softens the coarse step
      if (wr_dly)
        dly_ctrl_ff <= {13'h0000, pwdata[18:0]};
      if (wr_ref)
        ref_ctrl_ff <= {25'h0000000, pwdata[6:0]};
    end
  end

  // read word chosen from the address; unmapped offsets read zero
  reg [31:0] nxt_rdata;
  always @* begin
    case (paddr)
      `ADDR_DELAY_CTRL: nxt_rdata = dly_ctrl_ff;
      `ADDR_REF_CTRL:   nxt_rdata = ref_ctrl_ff;
      `ADDR_REF_POS:    nxt_rdata = {7'h00, pos_valid, flags_ff};
      `ADDR_STATUS:     nxt_rdata = {12'h000, cal_done, cal_busy,
                                     ramping, inv_act_ff,
                                     fine_act_ff, coarse_act_ff};
      default:          nxt_rdata = 32'h0000_0000;
    endcase
  end

  // read data comes from a flop, valid in the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      prdata <= nxt_rdata;
    end
  end

  // applied delay: ramp, direct load, or calibration search
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coarse_act_ff <= 8'h00;
      fine_act_ff   <= 8'h00;
      inv_act_ff    <= 1'b0;
      ramp_cnt_ff   <= 9'h000;
      cal_state_ff  <= CAL_IDLE;
      cal_wait_ff   <= 8'h00;
      cal_en_d_ff   <= 1'b0;
    end else if (clk_en) begin
      // a search starts on a fresh enable only, not on a held one
      cal_en_d_ff <= cal_en;
      case (cal_state_ff)
        CAL_IDLE: begin
          if (cal_en && !cal_en_d_ff) begin
            // search starts non-inverted at zero coarse delay
            coarse_act_ff <= 8'h00;
            inv_act_ff    <= 1'b0;
            cal_wait_ff   <= 8'h00;
            cal_state_ff  <= CAL_SETTLE;
          end else begin
            fine_act_ff <= dly_ctrl_ff[`DLY_FINE_LSB +: 8];
            inv_act_ff  <= dly_ctrl_ff[`DLY_INV_BIT];
            if (!ramp_en || wr_dly) begin
              // a fresh write restarts the ramp period cleanly
              ramp_cnt_ff <= 9'h000;
              if (!ramp_en)
                coarse_act_ff <= coarse_target;
            end else if (coarse_act_ff != coarse_target) begin
              if (ramp_tick) begin
                ramp_cnt_ff   <= 9'h000;
                coarse_act_ff <= ramp_step(coarse_act_ff, coarse_target,
                                           ramp_fast);
              end else begin
                ramp_cnt_ff <= ramp_cnt_ff + 9'h001;
              end
            end else begin
              ramp_cnt_ff <= 9'h000;
            end
          end
        end
        CAL_SETTLE: begin
          if (!cal_en)
            cal_state_ff <= CAL_IDLE;
          else if (cal_wait_ff == SETTLE_LEN - 1)
            cal_state_ff <= CAL_CHECK;
          else
            cal_wait_ff <= cal_wait_ff + 8'h01;
        end
        CAL_CHECK: begin
          cal_wait_ff <= 8'h00;
          if (!cal_en) begin
            cal_state_ff <= CAL_IDLE;
          end else if (ref_edge_aligned ||
                       (inv_act_ff && coarse_act_ff == 8'hff)) begin
            cal_state_ff <= CAL_DONE;
          end else begin
            // low coarse first in both polarities keeps clock loss low
            if (coarse_act_ff == 8'hff)
              inv_act_ff <= 1'b1;
            coarse_act_ff <= coarse_act_ff + 8'h01;
            cal_state_ff  <= CAL_SETTLE;
          end
        end
        CAL_DONE: begin
          // found setting holds until software rewrites the delay or clears the search enable
          if (wr_dly || !cal_en)
            cal_state_ff <= CAL_IDLE;
        end
        default: cal_state_ff <= CAL_IDLE;
      endcase
    end
  end

  // delay outputs to the analog clock path, shifting every clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_invert_select <= 1'b0;
      coarse_delay_code   <= 8'h00;
      fine_delay_code     <= 8'h00;
      total_delay_units   <= 24'h000000;
      ref_step_fine       <= 1'b0;
      sample_both_edges   <= 1'b0;
    end else if (clk_en) begin
      clock_invert_select <= inv_act_ff;
      coarse_delay_code   <= coarse_act_ff;
      fine_delay_code     <= fine_act_ff;
      total_delay_units   <= delay_units(inv_act_ff, coarse_act_ff,
                                         fine_act_ff);
      ref_step_fine       <= ref_ctrl_ff[`REF_FINE_BIT];
      sample_both_edges   <= ref_ctrl_ff[`REF_SINGLE_BIT];
    end
  end

  // position detector: a tap disagreeing with a neighbour on a
  // reference rise sits near an edge, so it is flagged
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff    <= {POS_W{1'b0}};
      edge_cnt_ff <= 2'd0;
      center_ff   <= 1'b0;
    end else if (clk_en) begin
      center_ff <= center_now;
      if (wr_ref) begin
        // zoom or mode change invalidates the old picture, but a rise
        // in the same cycle still counts, so no event is lost
        edge_cnt_ff <= {1'b0, ref_rise};
      end else if (ref_rise && !pos_valid) begin
        edge_cnt_ff <= edge_cnt_ff + 2'd1;
      end
      if (wr_ref || ref_rise) begin
        for (i = 1; i < POS_W - 1; i = i + 1)
          flags_ff[i] <= (flags_ff[i] & ~wr_ref) |
                         (ref_rise & edge_near(ref_tap_samples[i-1],
                                               ref_tap_samples[i],
                                               ref_tap_samples[i+1]));
      end
      // end positions lack a neighbour, so they are never judged safe
      flags_ff[0]       <= 1'b1;
      flags_ff[POS_W-1] <= 1'b1;
    end
  end

  // reference capture at the selected tap, one fixed clock edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_ff            <= 1'b0;
      ref_captured      <= 1'b0;
      ref_capture_pulse <= 1'b0;
    end else if (clk_en) begin
      // fixed two-flop path keeps capture latency equal at every start
      cap_ff            <= ref_tap_samples[sel];
      ref_captured      <= cap_ff;
      ref_capture_pulse <= cap_ff & ~ref_captured;
    end
  end

endmodule // aperture_ref_window

/* File: aperture_ref_window_sva.sv */
// assertions on the aperture delay and reference window block ports
// assumes one pclk domain and an apb master holding each request
`timescale 1ns/1ps
`include "aperture_ref_defs.vh"

module aperture_ref_window_sva #(
  parameter POS_W      = 24,
  parameter RAMP_LEN   = 384,
  parameter SETTLE_LEN = 64,
  parameter HALF_UNITS = 16'd2000,
  parameter CRS_UNITS  = 16'd20,
  parameter FINE_UNITS = 16'd1
) (
  input wire             pclk,
  input wire             presetn,
  input wire             clk_en,
  input wire             psel,
  input wire             penable,
  input wire             pwrite,
  input wire [11:0]      paddr,
  input wire [31:0]      pwdata,
  input wire [31:0]      prdata,
  input wire             pready,
  input wire             pslverr,
  input wire [POS_W-1:0] ref_tap_samples,
  input wire             ref_edge_aligned,
  input wire             clock_invert_select,
  input wire [7:0]       coarse_delay_code,
  input wire [7:0]       fine_delay_code,
  input wire [23:0]      total_delay_units,
  input wire             ref_step_fine,
  input wire             sample_both_edges,
  input wire             ref_captured,
  input wire             ref_capture_pulse
);
  wire [23:0] sum_w = (clock_invert_select ? HALF_UNITS : 16'h0) +
                      coarse_delay_code * CRS_UNITS +
                      fine_delay_code * FINE_UNITS;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr_dly;
    psel && penable && pwrite && clk_en && paddr == `ADDR_DELAY_CTRL;
  endsequence
  sequence wr_ref;
    psel && penable && pwrite && clk_en && paddr == `ADDR_REF_CTRL;
  endsequence

  a_delay_sum: assert property (total_delay_units == sum_w)
    else $error("total delay differs from its parts");
  a_coarse_direct: assert property (wr_dly and !pwdata[17] |->
    ##3 coarse_delay_code == $past(pwdata[7:0], 3))
    else $error("coarse code not applied directly");
  a_fine_follow: assert property (wr_dly |->
    ##3 fine_delay_code == $past(pwdata[15:8], 3))
    else $error("fine code not applied");
  a_invert_follow: assert property (wr_dly |->
    ##3 clock_invert_select == $past(pwdata[16], 3))
    else $error("invert not applied");
  a_ramp_hold: assert property (wr_dly and pwdata[17] |->
    ##2 $stable(coarse_delay_code) [*4])
    else $error("ramped coarse code jumped");
  a_zoom_copy: assert property (wr_ref |->
    ##2 ref_step_fine == $past(pwdata[4], 2))
    else $error("zoom not following control");
  a_mode_copy: assert property (wr_ref |->
    ##2 sample_both_edges == $past(pwdata[5], 2))
    else $error("dual edge mode not following control");
  a_pulse_single: assert property (ref_capture_pulse |=>
    !ref_capture_pulse)
    else $error("capture pulse longer than one cycle");
  a_pulse_rise: assert property ($rose(ref_captured) |->
    ##[0:1] ref_capture_pulse)
    else $error("capture rise without pulse");
  a_unmapped_err: assert property (psel && penable && paddr > 12'h00c
    |-> pslverr && pready)
    else $error("unmapped access not refused");
endmodule // aperture_ref_window_sva

bind aperture_ref_window aperture_ref_window_sva #(
  .POS_W(POS_W), .RAMP_LEN(RAMP_LEN), .SETTLE_LEN(SETTLE_LEN),
  .HALF_UNITS(HALF_UNITS), .CRS_UNITS(CRS_UNITS), .FINE_UNITS(FINE_UNITS)
) u_sva (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ref_tap_samples(ref_tap_samples), .ref_edge_aligned(ref_edge_aligned),
  .clock_invert_select(clock_invert_select),
  .coarse_delay_code(coarse_delay_code), .fine_delay_code(fine_delay_code),
  .total_delay_units(total_delay_units), .ref_step_fine(ref_step_fine),
  .sample_both_edges(sample_both_edges), .ref_captured(ref_captured),
  .ref_capture_pulse(ref_capture_pulse)
);

/* File: ref_clock_source.sv */
// periodic reference pulse as seen through the delay taps, plus comparator
// assumes pclk stands in for the device clock; pulses only while run
`timescale 1ns/1ps

module ref_clock_source #(
  parameter EDGE_POS  = 8,
  parameter ALIGN_CRS = 8'h10
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        run,
  input  wire [7:0]  coarse_delay_code,
  output wire [23:0] ref_tap_samples,
  output wire        ref_edge_aligned
);
  reg  [3:0]  phase_ff;
  reg  [23:0] taps_ff;
  wire [3:0]  nxt_phase = run ? phase_ff + 4'h1 : 4'h0;
  assign ref_tap_samples  = taps_ff;
  // trips at one code only, so the delay search stops at ALIGN_CRS
  assign ref_edge_aligned = (coarse_delay_code == ALIGN_CRS);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= 4'h0;
      taps_ff  <= 24'h0;
    end else begin
      phase_ff <= nxt_phase;
      // edge falls between taps EDGE_POS-1 and EDGE_POS, then all high
      if (run && phase_ff == 4'h0)
        taps_ff <= 24'hff_ffff << EDGE_POS;
      else if (run && phase_ff < 4'h4)
        taps_ff <= 24'hff_ffff;
      else
        taps_ff <= 24'h0;
    end
  end
endmodule // ref_clock_source

/* File: aperture_ref_window_tb.sv */
// self-checking bench for the aperture delay and reference window block
// assumes the reference source model and the bound checker
`timescale 1ns/1ps
`include "aperture_ref_defs.vh"

module aperture_ref_window_tb;
  localparam RLEN = 8;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] taps, total_delay_units;
  logic [7:0]  coarse_delay_code, fine_delay_code;
  logic aligned, clock_invert_select, ref_step_fine, sample_both_edges;
  logic ref_captured, ref_capture_pulse, run, err, seen;
  integer n_fail, n_checks;

  aperture_ref_window #(.RAMP_LEN(RLEN), .SETTLE_LEN(4)) i_dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_tap_samples(taps), .ref_edge_aligned(aligned),
    .clock_invert_select(clock_invert_select),
    .coarse_delay_code(coarse_delay_code),
    .fine_delay_code(fine_delay_code),
    .total_delay_units(total_delay_units), .ref_step_fine(ref_step_fine),
    .sample_both_edges(sample_both_edges), .ref_captured(ref_captured),
    .ref_capture_pulse(ref_capture_pulse));
  ref_clock_source i_src (.pclk(pclk), .presetn(presetn), .run(run),
    .coarse_delay_code(coarse_delay_code), .ref_tap_samples(taps),
    .ref_edge_aligned(aligned));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (ref_captured === 1'b1) seen <= 1'b1;

  task chk(input logic bad, input string m);
    n_checks++;
    if (bad !== 1'b0) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task final_report;
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task t_reset;
    apb(0, `ADDR_DELAY_CTRL, 0); chk(rd !== 32'h0, "delay reset");
    apb(0, `ADDR_STATUS, 0); chk(rd !== 32'h0, "status reset");
    apb(0, `ADDR_REF_POS, 0); chk(rd !== 32'h0080_0001, "pos reset");
    apb(0, 12'h010, 0); chk({err, rd} !== 33'h1_0000_0000, "unmapped");
  endtask
  task t_direct;
    apb(1, `ADDR_DELAY_CTRL, 32'h0001_ff05);
    repeat (3) @(posedge pclk);
    chk({clock_invert_select, fine_delay_code, coarse_delay_code}
        !== 17'h1_ff05, "direct delay");
    chk(total_delay_units !== 24'd2355, "delay sum");
    apb(0, `ADDR_STATUS, 0); chk(rd[16:0] !== 17'h1_ff05, "status");
    clk_en <= 1'b0;
    apb(1, `ADDR_DELAY_CTRL, 32'h0);
    clk_en <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(coarse_delay_code !== 8'h05, "write while frozen");
  endtask
  task t_ramp(input logic fast, input logic [7:0] tgt);
    integer n, cnt, st;
    st = fast ? 4 : 1;
    n = (tgt > coarse_delay_code ? tgt - coarse_delay_code
         : coarse_delay_code - tgt) + st - 1;
    n = n / st;
    apb(1, `ADDR_DELAY_CTRL, {13'h0, fast, 1'b1, 9'h0, tgt});
    cnt = 0;
    while (coarse_delay_code !== tgt && cnt < 4000) begin
      @(posedge pclk);
      cnt++;
    end
    chk(cnt < n * RLEN - 2 || cnt > n * RLEN + 4, "ramp timing");
    apb(0, `ADDR_STATUS, 0);
    chk({rd[17], rd[7:0]} !== {1'b0, tgt}, "ramp end");
  endtask
  task t_cal;
    apb(1, `ADDR_REF_CTRL, 32'h0000_0040);
    apb(0, `ADDR_STATUS, 0); chk(rd[18] !== 1'b1, "cal busy");
    repeat (100) @(posedge pclk);
    apb(0, `ADDR_STATUS, 0);
    chk({rd[19:18], rd[16], rd[7:0]} !== 11'h410, "cal result");
  endtask
  task t_pos;
    apb(1, `ADDR_REF_CTRL, 32'h0000_003f);
    apb(0, `ADDR_REF_CTRL, 0); chk(rd !== 32'h3f, "ref ctrl");
    chk({ref_step_fine, sample_both_edges} !== 2'b11, "zoom mode");
    run <= 1'b1;
    repeat (20) @(posedge pclk);
    apb(0, `ADDR_REF_POS, 0); chk(rd[24] !== 1'b0, "early valid");
    repeat (20) @(posedge pclk);
    apb(0, `ADDR_REF_POS, 0); chk(rd !== 32'h0180_0181, "flags");
    chk(seen !== 1'b1, "capture");
    run <= 1'b0;
  endtask

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, run, seen} = 0;
    clk_en = 1'b1;
    n_fail = 0;
    n_checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_direct;
    t_ramp(1'b1, 8'd30);
    t_ramp(1'b0, 8'd27);
    t_ramp(1'b1, 8'd0);
    t_pos;
    t_cal;
    final_report;
  end
  initial begin
    #(20000 * 5);
    n_fail++;
    final_report;
  end
endmodule // aperture_ref_window_tb
